// ### design/swc_link_regs.svh
// timing and field constants for the single-wire cascade link
`ifndef SWC_LINK_REGS_SVH
`define SWC_LINK_REGS_SVH

// system clock period
`define SWC_CLK_NS         20
// packet layout
`define SWC_PKT_BITS       6'd48
`define SWC_CMD_MSB        47
`define SWC_CMD_LSB        36
`define SWC_GRAY_MSB       35
`define SWC_CH0_LSB        0
`define SWC_CH1_LSB        12
`define SWC_CH2_LSB        24
`define SWC_WRITE_CMD      12'h3AA
// device bit timer width and pause multipliers (shift counts)
`define SWC_TMR_W          13
`define SWC_EOS_SHIFT      1
`define SWC_LAT_SHIFT      3
// host bit period and pulse shape
`define SWC_HOST_BIT_NS    1000
`define SWC_HOST_PULSE_NS  80
`define SWC_HOST_MARK_NS   240
`define SWC_HOST_BIT_CYC   10'(`SWC_HOST_BIT_NS / `SWC_CLK_NS)
`define SWC_HOST_PULSE_CYC 10'((`SWC_HOST_PULSE_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`define SWC_HOST_MARK_CYC  10'(`SWC_HOST_MARK_NS / `SWC_CLK_NS)
// host pauses after the last bit, in bit periods
`define SWC_HOST_EOS_CYC   10'(3 * `SWC_HOST_BIT_NS / `SWC_CLK_NS)
`define SWC_HOST_LAT_CYC   10'(16 * `SWC_HOST_BIT_NS / `SWC_CLK_NS)

`endif

// ### design/swc_pkg.sv
// types shared by both ends of the single-wire cascade link
package swc_pkg;

  // device receiver states, gray coded along idle-meas-recv-fwd
  typedef enum logic [1:0] {
    SWC_DEV_IDLE = 2'h0,
    SWC_DEV_MEAS = 2'h1,
    SWC_DEV_RECV = 2'h3,
    SWC_DEV_FWD  = 2'h2
  } swc_dev_state_t;

  // host transmitter states
  typedef enum logic [1:0] {
    SWC_HOST_IDLE  = 2'h0,
    SWC_HOST_BIT   = 2'h1,
    SWC_HOST_PAUSE = 2'h3
  } swc_host_state_t;

endpackage : swc_pkg

// ### design/swc_link_if.sv
// single data wire between host and first device, or between neighbouring devices
`timescale 1ns/10ps
interface swc_link_if;
  logic line; // self-timed serial data, driven by the host or an upstream device

  modport host   (output line);
  modport device (input line);
endinterface : swc_link_if

// ### design/swc_device.sv
// cascade device: self-timed receiver, packet shift register, gray latch and pwm
// Functional notes
// [R1] host latches once after all packets
// [R2] long low copies shift data to latch
// [R3] pwm restarts together with the latch
// [R4] packet is command plus three values
// [R5] host sends forty-eight times N bits
// [R6] no chain length limit in device
// [R7] host resends whole chain on change
// [R8] outputs off until data latched
// [R9] host sends msb first, command leading
// [R10] latch only when command is 3AAh
// [R11] host pauses after every packet
// [R12] host keeps one bit period throughout
// [R13] only lower 36 bits are latched
// [R14] first two edges set bit period
// [R15] early second edge decodes as one
// [R16] packet-end pause freezes, then forwards line
// [R17] bit fields map to channels and command
// [R18] pause kind chosen by low duration
`timescale 1ns/10ps
`include "swc_link_regs.svh"
module swc_device
  import swc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link from host or upstream device
  swc_link_if.device       link,
  // chain forwarding
  output logic             serial_line_out,
  // pwm sink outputs
  output logic [2:0]       sink_output,
  // latched gray levels
  output logic [11:0]      gray_value_ch0,
  output logic [11:0]      gray_value_ch1,
  output logic [11:0]      gray_value_ch2
);

  localparam logic [`SWC_TMR_W-1:0] TMR_MAX = '1;

  // pwm compare shared by the three channels
  function automatic logic gray_on(input logic [11:0] cnt, input logic [11:0] val);
    gray_on = (val != 12'h000) && (cnt != 12'h000) && (cnt <= val);
  endfunction : gray_on

  swc_dev_state_t          state_reg;
  swc_dev_state_t          state_next;
  logic                    line_prev_reg;
  logic [`SWC_TMR_W-1:0]   timer_reg;
  logic [`SWC_TMR_W-1:0]   timer_next;
  logic [`SWC_TMR_W-1:0]   period_reg;
  logic [`SWC_TMR_W-1:0]   period_next;
  logic                    mark_reg;
  logic                    mark_next;
  logic                    pending_reg;
  logic                    pending_next;
  logic [47:0]             shift_reg;
  logic [47:0]             shift_next;
  logic [35:0]             gray_reg;
  logic [35:0]             gray_next;
  logic [11:0]             pwm_cnt_reg;
  logic [11:0]             pwm_cnt_next;
  logic                    fwd_out_reg;
  logic [2:0]              sink_reg;

  // edge detect and derived thresholds
  wire                     line_rise;
  wire [`SWC_TMR_W-1:0]    half_period;
  wire [`SWC_TMR_W-1:0]    eos_limit;
  wire [`SWC_TMR_W-1:0]    lat_limit;
  wire                     eos_hit;
  wire                     lat_hit;
  wire                     bit_commit;
  wire                     cmd_ok;
  wire [`SWC_TMR_W-1:0]    timer_inc;

  assign line_rise   = link.line & ~line_prev_reg;
  assign half_period = period_reg >> 1;
  // [R18] thresholds from bit period
  assign eos_limit   = period_reg << `SWC_EOS_SHIFT;
  assign lat_limit   = period_reg << `SWC_LAT_SHIFT;
  assign eos_hit     = timer_reg >= eos_limit;
  assign lat_hit     = timer_reg >= lat_limit;
  // [R15] decision at half period
  assign bit_commit  = pending_reg && (timer_reg >= half_period);
  // [R10] write command check
  assign cmd_ok      = shift_reg[`SWC_CMD_MSB:`SWC_CMD_LSB] == `SWC_WRITE_CMD;
  assign timer_inc   = (timer_reg == TMR_MAX) ? timer_reg : timer_reg + 1'b1;

  // receiver sequence and latch transfer
  always_comb begin
    state_next   = state_reg;
    timer_next   = timer_inc;
    period_next  = period_reg;
    mark_next    = mark_reg;
    pending_next = pending_reg;
    shift_next   = shift_reg;
    gray_next    = gray_reg;
    pwm_cnt_next = pwm_cnt_reg + 12'h001;
    unique case (state_reg)
      SWC_DEV_IDLE: begin
        if (line_rise) begin
          timer_next = '0;
          state_next = SWC_DEV_MEAS;
        end
      end
      SWC_DEV_MEAS: begin
        // [R14] second edge stores period
        if (line_rise) begin
          // timer restarts at zero, so count the edge cycle too
          period_next  = timer_inc;
          shift_next   = {shift_reg[46:0], 1'b0};
          timer_next   = '0;
          mark_next    = 1'b0;
          pending_next = 1'b1;
          state_next   = SWC_DEV_RECV;
        end else if (timer_reg == TMR_MAX) begin
          state_next = SWC_DEV_IDLE; // line went quiet, restart
        end
      end
      SWC_DEV_RECV: begin
        // [R9] bits enter at lsb, msb first
        if (bit_commit) begin
          shift_next   = {shift_reg[46:0], mark_reg};
          pending_next = 1'b0;
        end
        if (line_rise) begin
          if (pending_reg && !bit_commit) begin
            // [R15] early edge marks one
            mark_next = 1'b1;
          end else begin
            timer_next   = '0;
            mark_next    = 1'b0;
            pending_next = 1'b1;
          end
        end else if (eos_hit) begin
          // [R16] freeze shift register
          state_next = SWC_DEV_FWD;
        end
      end
      SWC_DEV_FWD: begin
        if (line_rise) begin
          timer_next = '0;
        end else if (lat_hit) begin
          // [R2] copy on latch pause
          if (cmd_ok) begin
            // [R13] lower 36 bits only
            gray_next    = shift_reg[`SWC_GRAY_MSB:0];
            // [R3] pwm restarts now
            pwm_cnt_next = 12'h000;
          end
          timer_next = '0;
          state_next = SWC_DEV_IDLE;
        end
      end
    endcase
  end

  // receiver registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= SWC_DEV_IDLE;
      line_prev_reg <= 1'b0;
      timer_reg     <= '0;
      period_reg    <= '0;
      mark_reg      <= 1'b0;
      pending_reg   <= 1'b0;
      shift_reg     <= 48'h000000000000;
    end else begin
      state_reg     <= state_next;
      line_prev_reg <= link.line;
      timer_reg     <= timer_next;
      period_reg    <= period_next;
      mark_reg      <= mark_next;
      pending_reg   <= pending_next;
      shift_reg     <= shift_next;
    end
  end

  // gray latch, pwm counter and forwarding
  always_ff @(posedge clk) begin
    if (rst) begin
      // [R8] outputs off after reset
      gray_reg    <= 36'h000000000;
      pwm_cnt_reg <= 12'h000;
      fwd_out_reg <= 1'b0;
      sink_reg    <= 3'h0;
    end else begin
      gray_reg    <= gray_next;
      pwm_cnt_reg <= pwm_cnt_next;
      // [R16] buffered line forward
      // [R6] no packet counting
      fwd_out_reg <= (state_reg == SWC_DEV_FWD) & link.line;
      sink_reg    <= {gray_on(pwm_cnt_reg, gray_value_ch2),
                      gray_on(pwm_cnt_reg, gray_value_ch1),
                      gray_on(pwm_cnt_reg, gray_value_ch0)};
    end
  end

  // [R17] channel field mapping
  // [R4] three 12-bit values
  assign gray_value_ch0  = gray_reg[`SWC_CH0_LSB +: 12];
  assign gray_value_ch1  = gray_reg[`SWC_CH1_LSB +: 12];
  assign gray_value_ch2  = gray_reg[`SWC_CH2_LSB +: 12];
  assign serial_line_out = fwd_out_reg;
  assign sink_output     = sink_reg;

endmodule : swc_device

// ### design/swc_host.sv
// host end: sends self-timed packets, packet-end and latch pauses
`timescale 1ns/10ps
`include "swc_link_regs.svh"
module swc_host
  import swc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link to first device
  swc_link_if.host         link,
  // packet request
  input  wire logic        pkt_valid,
  input  wire logic [47:0] pkt_data,
  input  wire logic        pkt_last,
  output logic             pkt_ready,
  // status
  output logic             busy
);

  swc_host_state_t         state_reg;
  swc_host_state_t         state_next;
  logic [47:0]             data_reg;
  logic [47:0]             data_next;
  logic                    last_reg;
  logic                    last_next;
  logic [5:0]              bit_cnt_reg;
  logic [5:0]              bit_cnt_next;
  logic [9:0]              tick_reg;
  logic [9:0]              tick_next;
  logic                    line_reg;

  // pulse shaping for the current bit
  wire                     start_pulse;
  wire                     mark_pulse;
  wire                     bit_end;
  wire [9:0]               pause_len;

  assign start_pulse = tick_reg < `SWC_HOST_PULSE_CYC;
  assign mark_pulse  = data_reg[47] && (tick_reg >= `SWC_HOST_MARK_CYC)
                       && (tick_reg < `SWC_HOST_MARK_CYC + `SWC_HOST_PULSE_CYC);
  // [R12] one fixed bit period
  assign bit_end     = tick_reg == `SWC_HOST_BIT_CYC - 10'd1;
  // [R11] pause after each packet
  // [R1] latch pause after last
  assign pause_len   = last_reg ? `SWC_HOST_LAT_CYC : `SWC_HOST_EOS_CYC;
  assign pkt_ready   = state_reg == SWC_HOST_IDLE;
  assign busy        = state_reg != SWC_HOST_IDLE;

  // transmit sequence
  always_comb begin
    state_next   = state_reg;
    data_next    = data_reg;
    last_next    = last_reg;
    bit_cnt_next = bit_cnt_reg;
    tick_next    = tick_reg + 10'd1;
    unique case (state_reg)
      SWC_HOST_IDLE: begin
        tick_next = 10'd0;
        // [R5] one packet per device
        // [R7] user resends whole chain
        if (pkt_valid) begin
          data_next    = pkt_data;
          last_next    = pkt_last;
          bit_cnt_next = 6'd0;
          state_next   = SWC_HOST_BIT;
        end
      end
      SWC_HOST_BIT: begin
        if (bit_end) begin
          tick_next    = 10'd0;
          // [R9] msb first
          data_next    = {data_reg[46:0], 1'b0};
          bit_cnt_next = bit_cnt_reg + 6'd1;
          // [R4] 48 bits per packet
          if (bit_cnt_reg == `SWC_PKT_BITS - 6'd1) begin
            state_next = SWC_HOST_PAUSE;
          end
        end
      end
      SWC_HOST_PAUSE: begin
        if (tick_reg == pause_len - 10'd1) begin
          state_next = SWC_HOST_IDLE;
        end
      end
      default: begin
        state_next = SWC_HOST_IDLE;
      end
    endcase
  end

  // host registers, line is registered
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= SWC_HOST_IDLE;
      data_reg    <= 48'h000000000000;
      last_reg    <= 1'b0;
      bit_cnt_reg <= 6'd0;
      tick_reg    <= 10'd0;
      line_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      data_reg    <= data_next;
      last_reg    <= last_next;
      bit_cnt_reg <= bit_cnt_next;
      tick_reg    <= tick_next;
      line_reg    <= (state_reg == SWC_HOST_BIT) && (start_pulse || mark_pulse);
    end
  end

  assign link.line = line_reg;

endmodule : swc_host

// ### bench/swc_link_monitor.sv
// assertions on the host link and the first device of the chain
`timescale 1ns/10ps
module swc_link_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // host side of the link
  input  wire logic        line,
  input  wire logic        pkt_valid,
  input  wire logic        pkt_ready,
  input  wire logic        busy,
  // first device outputs
  input  wire logic        serial_line_out,
  input  wire logic [2:0]  sink_output,
  input  wire logic [11:0] gray_value_ch0
);
  // latch low of 8 periods of 50, less input sampling slack
  localparam int LATCH_LOW = 396;
  logic [9:0]  low_reg;
  logic [11:0] busy_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // length of the current low run and busy run
  always_ff @(posedge clk) begin
    low_reg  <= (line || rst) ? 10'h000 : low_reg + {9'h000, ~&low_reg};
    busy_reg <= busy ? busy_reg + 12'h001 : 12'h000;
  end

  sequence s_take; pkt_valid && pkt_ready; endsequence
  sequence s_start; !pkt_ready ##1 line; endsequence
  sequence s_pulse; line [*4] ##1 !line; endsequence

  property p_take; s_take |=> s_start; endproperty
  a_take: assert property (p_take) else $error("line did not start after take");
  property p_reset_idle;
    @(posedge clk) disable iff (1'b0)
    rst |=> !line && !busy && sink_output == 3'h0 && !serial_line_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
  property p_off_zero; gray_value_ch0 == 12'h000 ##1 gray_value_ch0 == 12'h000 |-> !sink_output[0];
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("channel on with zero value");
  property p_restart;
    $changed(gray_value_ch0) && gray_value_ch0 != 12'h000 |-> ##[1:4] sink_output[0];
  endproperty
  a_restart: assert property (p_restart) else $error("pwm did not restart on latch");
  property p_latch_low; $changed(gray_value_ch0) |-> low_reg >= LATCH_LOW; endproperty
  a_latch_low: assert property (p_latch_low) else $error("latch without long low");
  property p_fwd; serial_line_out |-> $past(line); endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded level not from line");
  property p_pulse; $rose(line) |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("line pulse not four cycles");
  property p_len; $fell(busy) |-> busy_reg inside {[2550:2551], [3200:3201]}; endproperty
  a_len: assert property (p_len) else $error("packet length wrong");
  property p_idle_quiet; !busy |-> !line; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("line active while idle");
endmodule : swc_link_monitor

// ### bench/test_single_wire_cascade_latch.sv
// self-checking bench: host driving a chain of two devices
`timescale 1ns/10ps
module test_single_wire_cascade_latch;
  logic        clk;
  logic        rst;
  logic        pkt_valid;
  logic [47:0] pkt_data;
  logic        pkt_last;
  logic        pkt_ready;
  logic        busy;
  logic        fwd_line;
  logic [2:0]  sink_a;
  logic [2:0]  sink_b;
  logic [11:0] gray_a [3];
  logic [11:0] gray_b [3];
  logic [35:0] exp_a;
  logic [35:0] exp_b;
  logic [11:0] cmd_a [3] = '{12'h3AA, 12'h3AB, 12'h3AA};
  logic [11:0] cmd_b [3] = '{12'h3AA, 12'h3AA, 12'h2AA};
  logic [35:0] dat_a [3] = '{36'h123456789, 36'hAAAAAAAAA, 36'hFFF000ABC};
  logic [35:0] dat_b [3] = '{36'hFFF000001, 36'h555555555, 36'h0000000FF};
  int          fail_count;
  int          check_count;

  // host feeds the first device, which forwards to the second
  swc_link_if link_a ();
  swc_link_if link_b ();
  assign link_b.line = fwd_line;

  swc_host swc_host_i (.clk(clk), .rst(rst), .link(link_a), .pkt_valid(pkt_valid),
    .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready), .busy(busy));
  swc_device swc_device_i (.clk(clk), .rst(rst), .link(link_a), .serial_line_out(fwd_line),
    .sink_output(sink_a), .gray_value_ch0(gray_a[0]), .gray_value_ch1(gray_a[1]),
    .gray_value_ch2(gray_a[2]));
  swc_device swc_device_b_i (.clk(clk), .rst(rst), .link(link_b), .serial_line_out(),
    .sink_output(sink_b), .gray_value_ch0(gray_b[0]), .gray_value_ch1(gray_b[1]),
    .gray_value_ch2(gray_b[2]));
  swc_link_monitor swc_link_monitor_i (.clk(clk), .rst(rst), .line(link_a.line),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .busy(busy), .serial_line_out(fwd_line),
    .sink_output(sink_a), .gray_value_ch0(gray_a[0]));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // compare and count
  task check_value(input logic [47:0] seen, input logic [47:0] expected);
    check_count++;
    if (seen !== expected) begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check_value

  // verdict and end of run
  task test_done;
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // offer one packet, then wait for the host to go idle
  task send(input logic [11:0] cmd, input logic [35:0] gray, input logic last);
    int n;
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_data  <= {cmd, gray};
    pkt_last  <= last;
    @(posedge clk);
    pkt_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy && n < 4000);
    check_value({47'h0, busy}, 48'h0);
  endtask : send

  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    pkt_valid = 1'b0;
    pkt_data = 48'h0;
    pkt_last = 1'b0;
    fail_count = 0;
    check_count = 0;
    exp_a = 36'h0;
    exp_b = 36'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_value({42'h0, sink_a, sink_b}, 48'h0);
    for (int r = 0; r < 3; r++) begin
      send(cmd_a[r], dat_a[r], 1'b0);
      check_value({12'h0, gray_a[2], gray_a[1], gray_a[0]}, {12'h0, exp_a});
      send(cmd_b[r], dat_b[r], 1'b1);
      if (cmd_a[r] == 12'h3AA) exp_a = dat_a[r];
      if (cmd_b[r] == 12'h3AA) exp_b = dat_b[r];
      check_value({12'h0, gray_a[2], gray_a[1], gray_a[0]}, {12'h0, exp_a});
      check_value({12'h0, gray_b[2], gray_b[1], gray_b[0]}, {12'h0, exp_b});
      if (r == 0) begin
        check_value({42'h0, sink_a, sink_b}, {42'h0, 3'h3, 3'h4});
      end
    end
    test_done();
  end
endmodule : test_single_wire_cascade_latch
